// *** csscr_top.sv ***
// Serial-programmed control bank of a motherboard clock synthesizer.
// Function
// RULE_01 - Byte0 bit7 picks narrow or wide centre spread.
// RULE_02 - Byte0 bit3 picks strap or software index.
// RULE_03 - Software index is bit2 then bits 6:4.
// RULE_04 - Byte0 bit1 turns spread modulation on.
// RULE_05 - Byte0 bit0 tristates every clock output.
// RULE_06 - Byte1 bit5 clear forces down spread.
// RULE_07 - Byte1 bits 3:1 enable processor clocks 2:0.
// RULE_08 - Byte2 bits 6:0 enable PCI clocks.
// RULE_09 - Byte3 bit7 picks 24 or 48 MHz.
// RULE_10 - Byte3 enables USB, dual, reference outputs.
// RULE_11 - Byte4 enables memory clocks 13 to 8.
// RULE_12 - Latched strap levels read back, read-only.
// RULE_13 - Byte5 enables memory clocks 7 to 0.
// RULE_14 - Byte6 is a fixed read-only identity.
// RULE_15 - Byte0 powers up as all zeros.
// RULE_16 - Host writes address, two dummies, then data.
// RULE_17 - Reads return bytes from zero until stop.
// RULE_18 - Defaults load only at power-up.
// RULE_19 - Straps latched once after power-up.
`timescale 1ns/1ps
`default_nettype none
`include "csscr_cfg.svh"

module csscr_top #(
  parameter logic [7:0] CHIP_ID = 8'ha5  // Arbitrary neutral value.
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  input  wire logic [3:0]            freq_strap_i,
  output logic                       strap_valid_o,
  output csscr_pkg::csscr_ctrl_type  ctrl_o
);

  typedef struct packed {
    logic                           scl_meta;
    logic                           scl_sync;
    logic                           scl_prev;
    logic                           sda_meta;
    logic                           sda_sync;
    logic                           sda_prev;
    logic [3:0]                     strap_meta;
    logic [3:0]                     strap_sync;
    logic [3:0]                     strap_cnt;
    logic                           strap_done;
    logic [3:0]                     straps;
    csscr_pkg::csscr_i2c_state_type st;
    logic [3:0]                     bit_cnt;
    logic [7:0]                     shreg;
    logic                           rw;
    logic [1:0]                     byte_no;
    logic [2:0]                     idx;
    logic                           nack;
    logic                           sda_out;
    logic                           sda_oe;
    logic                           wr_en;
    logic [2:0]                     wr_idx;
    logic [7:0]                     wr_data;
    csscr_pkg::csscr_ctrl_type      ctrl;
  } csscr_top_state_type;

  csscr_top_state_type       s;
  csscr_top_state_type       next_s;
  csscr_pkg::csscr_regs_type regs;
  logic [7:0]                bank_rd;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_seen;
  logic                      stop_seen;

  // Index advances but parks at the unmapped slot past the identity byte.
  function automatic logic [2:0] next_idx(input logic [2:0] idx);
    next_idx = (idx == `CSSCR_OFS_LAST) ? idx : idx + 3'h1;
  endfunction : next_idx

  // -------------------------------------------------------------------
  // Register storage
  // -------------------------------------------------------------------
  csscr_reg_bank #(
    .CHIP_ID (CHIP_ID)
  ) u_bank (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (s.wr_en),
    .wr_idx_i  (s.wr_idx),
    .wr_data_i (s.wr_data),
    .rd_idx_i  (s.idx),
    .straps_i  (s.straps),
    .rd_data_o (bank_rd),
    .regs_o    (regs)
  );

  // -------------------------------------------------------------------
  // Bus edge and condition detection
  // -------------------------------------------------------------------
  // Only the second synchroniser stage and its delayed copy are looked at.
  assign scl_rise   = s.scl_sync & ~s.scl_prev;
  assign scl_fall   = ~s.scl_sync & s.scl_prev;
  assign start_seen = s.scl_sync & s.scl_prev & s.sda_prev & ~s.sda_sync;
  assign stop_seen  = s.scl_sync & s.scl_prev & ~s.sda_prev & s.sda_sync;

  // Next-state logic for synchronisers, strap latch, serial slave and the
  // registered control outputs.
  always_comb begin
    next_s            = s;
    next_s.scl_meta   = scl_i;
    next_s.scl_sync   = s.scl_meta;
    next_s.scl_prev   = s.scl_sync;
    next_s.sda_meta   = sda_i;
    next_s.sda_sync   = s.sda_meta;
    next_s.sda_prev   = s.sda_sync;
    next_s.strap_meta = freq_strap_i;
    next_s.strap_sync = s.strap_meta;
    next_s.sda_out    = 1'b0;
    next_s.wr_en      = 1'b0;

    // Straps are caught once after reset settles and never again, since
    // the shared pins turn into clock outputs afterwards.
    if (!s.strap_done) begin
      if (s.strap_cnt == `CSSCR_STRAP_SETTLE_CYC) begin
        next_s.straps     = s.strap_sync; // RULE_19
        next_s.strap_done = 1'b1;
      end else begin
        next_s.strap_cnt = s.strap_cnt + 4'h1;
      end
    end

    // A start restarts framing anywhere; a stop always frees the line.
    if (start_seen) begin
      next_s.st      = csscr_pkg::ST_ADDR;
      next_s.bit_cnt = 4'h0;
      next_s.byte_no = 2'h0;
      next_s.idx     = `CSSCR_OFS_FREQ_SPREAD; // RULE_17
      next_s.sda_oe  = 1'b0;
    end else if (stop_seen) begin
      next_s.st     = csscr_pkg::ST_IDLE;
      next_s.sda_oe = 1'b0;
    end else begin
      unique case (s.st)
        csscr_pkg::ST_IDLE: ;
        csscr_pkg::ST_ADDR, csscr_pkg::ST_WBYTE: begin
          if (scl_rise && s.bit_cnt != `CSSCR_BYTE_BITS) begin
            next_s.shreg   = {s.shreg[6:0], s.sda_sync};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall && s.bit_cnt == `CSSCR_BYTE_BITS) begin
            next_s.bit_cnt = 4'h0;
            if (s.st == csscr_pkg::ST_ADDR) begin
              if (s.shreg[7:1] == `CSSCR_SLAVE_ADDR) begin
                next_s.st     = csscr_pkg::ST_ACK;
                next_s.sda_oe = 1'b1;
                next_s.rw     = s.shreg[0];
              end else begin
                next_s.st = csscr_pkg::ST_IDLE;
              end
            end else begin
              next_s.st     = csscr_pkg::ST_ACK;
              next_s.sda_oe = 1'b1;
              // Command and count bytes are acknowledged and dropped.
              if (s.byte_no != 2'h2) begin
                next_s.byte_no = s.byte_no + 2'h1; // RULE_16
              end else begin
                next_s.wr_en   = 1'b1;
                next_s.wr_idx  = s.idx;
                next_s.wr_data = s.shreg;
                next_s.idx     = next_idx(s.idx);
              end
            end
          end
        end
        csscr_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (s.rw) begin
              next_s.st      = csscr_pkg::ST_RBYTE;
              next_s.shreg   = {bank_rd[6:0], 1'b0};
              next_s.sda_oe  = ~bank_rd[7]; // RULE_17
              next_s.bit_cnt = 4'h1;
            end else begin
              next_s.st     = csscr_pkg::ST_WBYTE;
              next_s.sda_oe = 1'b0;
            end
          end
        end
        csscr_pkg::ST_RBYTE: begin
          if (scl_fall) begin
            if (s.bit_cnt == `CSSCR_BYTE_BITS) begin
              next_s.st     = csscr_pkg::ST_RACK;
              next_s.sda_oe = 1'b0;
              next_s.idx    = next_idx(s.idx);
            end else begin
              next_s.sda_oe  = ~s.shreg[7];
              next_s.shreg   = {s.shreg[6:0], 1'b0};
              next_s.bit_cnt = s.bit_cnt + 4'h1;
            end
          end
        end
        csscr_pkg::ST_RACK: begin
          if (scl_rise) begin
            next_s.nack = s.sda_sync;
          end else if (scl_fall) begin
            if (s.nack) begin
              next_s.st = csscr_pkg::ST_IDLE;
            end else begin
              next_s.st      = csscr_pkg::ST_RBYTE;
              next_s.shreg   = {bank_rd[6:0], 1'b0};
              next_s.sda_oe  = ~bank_rd[7]; // RULE_17
              next_s.bit_cnt = 4'h1;
            end
          end
        end
        default: next_s.st = csscr_pkg::ST_IDLE;
      endcase
    end

    // Control outputs are re-registered so they come straight from flops.
    next_s.ctrl.sw_select  = regs.freq_spread[`CSSCR_B0_SW_SELECT];
    next_s.ctrl.freq_index = regs.freq_spread[`CSSCR_B0_SW_SELECT] ?
      {regs.freq_spread[`CSSCR_B0_SW_MSB],
       regs.freq_spread[6:4]} : s.straps; // RULE_02 RULE_03
    next_s.ctrl.spread_en  =
      regs.freq_spread[`CSSCR_B0_SPREAD_EN]; // RULE_04
    if (!regs.cpu_en[`CSSCR_B1_CENTER_TYPE]) begin
      next_s.ctrl.spread_mode = csscr_pkg::SPREAD_DOWN_HALF; // RULE_06
    end else if (regs.freq_spread[`CSSCR_B0_CENTER_WIDE]) begin
      next_s.ctrl.spread_mode = csscr_pkg::SPREAD_CENTER_WIDE; // RULE_01
    end else begin
      next_s.ctrl.spread_mode = csscr_pkg::SPREAD_CENTER_HALF;
    end
    next_s.ctrl.tristate_all =
      regs.freq_spread[`CSSCR_B0_TRISTATE]; // RULE_05
    next_s.ctrl.processor_en = regs.cpu_en[3:1]; // RULE_07
    next_s.ctrl.pci_en       = regs.pci_en[6:0]; // RULE_08
    next_s.ctrl.memory_en    = {regs.mem_high[7:4], regs.mem_high[2],
      regs.mem_high[0], regs.mem_low}; // RULE_11 RULE_13
    next_s.ctrl.dual_24mhz   = regs.misc[`CSSCR_B3_DUAL_24MHZ]; // RULE_09
    next_s.ctrl.usb_en       = regs.misc[`CSSCR_B3_USB_EN]; // RULE_10
    next_s.ctrl.dual_en      = regs.misc[`CSSCR_B3_DUAL_EN]; // RULE_10
    next_s.ctrl.reference_en = regs.misc[1:0]; // RULE_10
  end

  // Control outputs power up at their register defaults. RULE_18
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s                   <= '0;
      s.scl_meta          <= 1'b1;
      s.scl_sync          <= 1'b1;
      s.scl_prev          <= 1'b1;
      s.sda_meta          <= 1'b1;
      s.sda_sync          <= 1'b1;
      s.sda_prev          <= 1'b1;
      s.st                <= csscr_pkg::ST_IDLE;
      s.ctrl.spread_mode  <= csscr_pkg::SPREAD_CENTER_HALF;
      s.ctrl.processor_en <= 3'h7;
      s.ctrl.pci_en       <= 7'h7f;
      s.ctrl.memory_en    <= 14'h3fff;
      s.ctrl.usb_en       <= 1'b1;
      s.ctrl.dual_en      <= 1'b1;
      s.ctrl.dual_24mhz   <= 1'b1;
      s.ctrl.reference_en <= 2'h3;
    end else begin
      s <= next_s;
    end
  end

  assign sda_o         = s.sda_out;
  assign sda_oe_o      = s.sda_oe;
  assign strap_valid_o = s.strap_done;
  assign ctrl_o        = s.ctrl;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  a_sw_index_order: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) regs.freq_spread[3] |=>
    ctrl_o.freq_index == {$past(regs.freq_spread[2]),
    $past(regs.freq_spread[6:4])}) else $error("Sw index."); // RULE_03
  a_hw_index_src: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) !regs.freq_spread[3] |=>
    ctrl_o.freq_index == $past(s.straps))
    else $error("Strap index not used."); // RULE_02
  a_down_spread: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) !regs.cpu_en[5] |=>
    ctrl_o.spread_mode == csscr_pkg::SPREAD_DOWN_HALF)
    else $error("Down spread not forced."); // RULE_06
  a_wide_spread: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) regs.cpu_en[5] && regs.freq_spread[7] |=>
    ctrl_o.spread_mode == csscr_pkg::SPREAD_CENTER_WIDE)
    else $error("Wide centre spread missing."); // RULE_01
  a_tristate_map: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) ##1 ctrl_o.tristate_all ==
    $past(regs.freq_spread[0]) && ctrl_o.spread_en ==
    $past(regs.freq_spread[1])) else $error("Byte0 map."); // RULE_05
  a_cpu_mem_map: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) ##1 ctrl_o.processor_en ==
    $past(regs.cpu_en[3:1]) && ctrl_o.memory_en[7:0] ==
    $past(regs.mem_low)) else $error("Enable map."); // RULE_07
  a_strap_frozen: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) s.strap_done |=> $stable(s.straps))
    else $error("Straps changed after latch."); // RULE_19
  a_dummy_no_write: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) s.byte_no != 2'h2 |=> !s.wr_en)
    else $error("Dummy byte written."); // RULE_16
  c_write_data: cover property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) s.wr_en);
  c_read_byte: cover property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) s.st == csscr_pkg::ST_RACK);
  c_sw_select: cover property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) ctrl_o.sw_select);

endmodule : csscr_top
`default_nettype wire

// *** csscr_cfg.svh ***
// Offsets, field positions, reset values and counts of the control bank.
`ifndef CSSCR_CFG_SVH
`define CSSCR_CFG_SVH

// ---------------------------------------------------------------------
// Serial slave address and register offsets
// ---------------------------------------------------------------------
`define CSSCR_SLAVE_ADDR       7'h69
`define CSSCR_OFS_FREQ_SPREAD  3'h0
`define CSSCR_OFS_CPU_EN       3'h1
`define CSSCR_OFS_PCI_EN       3'h2
`define CSSCR_OFS_MISC         3'h3
`define CSSCR_OFS_MEM_HIGH     3'h4
`define CSSCR_OFS_MEM_LOW      3'h5
`define CSSCR_OFS_IDENTITY     3'h6
`define CSSCR_OFS_LAST         3'h7

// ---------------------------------------------------------------------
// Power-up values and software-writable bit masks
// ---------------------------------------------------------------------
`define CSSCR_RST_FREQ_SPREAD  8'h00
`define CSSCR_RST_CPU_EN       8'h7f
`define CSSCR_RST_PCI_EN       8'hff
`define CSSCR_RST_MISC         8'hbf
`define CSSCR_RST_MEM_HIGH     8'hf5
`define CSSCR_RST_MEM_LOW      8'hff
`define CSSCR_WMASK_CPU_EN     8'h7f
`define CSSCR_WMASK_MISC       8'hbf
`define CSSCR_WMASK_MEM_HIGH   8'hf5

// ---------------------------------------------------------------------
// Field positions and timing counts
// ---------------------------------------------------------------------
`define CSSCR_B0_CENTER_WIDE   7
`define CSSCR_B0_SW_SELECT     3
`define CSSCR_B0_SW_MSB        2
`define CSSCR_B0_SPREAD_EN     1
`define CSSCR_B0_TRISTATE      0
`define CSSCR_B1_CENTER_TYPE   5
`define CSSCR_B3_DUAL_24MHZ    7
`define CSSCR_B3_USB_EN        5
`define CSSCR_B3_DUAL_EN       4
`define CSSCR_STRAP_SETTLE_CYC 4'h4
`define CSSCR_BYTE_BITS        4'h8

`endif

// *** csscr_pkg.sv ***
// Types shared by the control bank and its serial front end.
`default_nettype none
package csscr_pkg;

  // -------------------------------------------------------------------
  // Enumerations
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPREAD_CENTER_HALF = 2'h0,
    SPREAD_CENTER_WIDE = 2'h1,
    SPREAD_DOWN_HALF   = 2'h2
  } csscr_spread_type;

  // Gray codes along address, ack, write byte and read byte.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_ACK   = 3'h3,
    ST_WBYTE = 3'h2,
    ST_RBYTE = 3'h6,
    ST_RACK  = 3'h7
  } csscr_i2c_state_type;

  // -------------------------------------------------------------------
  // Carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mem_low;
    logic [7:0] mem_high;
    logic [7:0] misc;
    logic [7:0] pci_en;
    logic [7:0] cpu_en;
    logic [7:0] freq_spread;
  } csscr_regs_type;

  typedef struct packed {
    logic [3:0]       freq_index;
    logic             sw_select;
    logic             spread_en;
    csscr_spread_type spread_mode;
    logic             tristate_all;
    logic [2:0]       processor_en;
    logic [6:0]       pci_en;
    logic [13:0]      memory_en;
    logic             usb_en;
    logic             dual_en;
    logic             dual_24mhz;
    logic [1:0]       reference_en;
  } csscr_ctrl_type;

endpackage : csscr_pkg
`default_nettype wire

// *** csscr_reg_bank.sv ***
// Byte-wide control registers with masked writes and registered read-back.
`timescale 1ns/1ps
`default_nettype none
`include "csscr_cfg.svh"

module csscr_reg_bank #(
  parameter logic [7:0] CHIP_ID = 8'ha5  // Arbitrary neutral value.
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  wr_en_i,
  input  wire logic [2:0]            wr_idx_i,
  input  wire logic [7:0]            wr_data_i,
  input  wire logic [2:0]            rd_idx_i,
  input  wire logic [3:0]            straps_i,
  output logic [7:0]                 rd_data_o,
  output csscr_pkg::csscr_regs_type  regs_o
);

  typedef struct packed {
    csscr_pkg::csscr_regs_type regs;
    logic [7:0]                rd_data;
  } csscr_bank_state_type;

  csscr_bank_state_type s;
  csscr_bank_state_type next_s;

  // Keeps the read-only bits of a byte and takes the rest from the write.
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (new_v & mask) | (old_v & ~mask);
  endfunction : merge

  // Writes land one byte at a time; read data is always re-registered,
  // so a latched strap change shows up one cycle later.
  always_comb begin
    next_s = s;
    if (wr_en_i) begin
      unique case (wr_idx_i)
        `CSSCR_OFS_FREQ_SPREAD: next_s.regs.freq_spread = wr_data_i;
        `CSSCR_OFS_CPU_EN: next_s.regs.cpu_en =
          merge(s.regs.cpu_en, wr_data_i, `CSSCR_WMASK_CPU_EN); // RULE_12
        `CSSCR_OFS_PCI_EN: next_s.regs.pci_en = wr_data_i; // RULE_08
        `CSSCR_OFS_MISC: next_s.regs.misc =
          merge(s.regs.misc, wr_data_i, `CSSCR_WMASK_MISC); // RULE_12
        `CSSCR_OFS_MEM_HIGH: next_s.regs.mem_high =
          merge(s.regs.mem_high, wr_data_i, `CSSCR_WMASK_MEM_HIGH);
        `CSSCR_OFS_MEM_LOW: next_s.regs.mem_low = wr_data_i; // RULE_13
        default: ; // Identity byte and beyond ignore writes. RULE_14
      endcase
    end
    unique case (rd_idx_i)
      `CSSCR_OFS_FREQ_SPREAD: next_s.rd_data = s.regs.freq_spread;
      `CSSCR_OFS_CPU_EN: next_s.rd_data = {straps_i[2],
                                           s.regs.cpu_en[6:0]}; // RULE_12
      `CSSCR_OFS_PCI_EN: next_s.rd_data = s.regs.pci_en;
      `CSSCR_OFS_MISC: next_s.rd_data = {s.regs.misc[7], straps_i[0],
                                         s.regs.misc[5:0]};
      `CSSCR_OFS_MEM_HIGH: next_s.rd_data = {s.regs.mem_high[7:4],
        straps_i[1], s.regs.mem_high[2], straps_i[3], s.regs.mem_high[0]};
      `CSSCR_OFS_MEM_LOW: next_s.rd_data = s.regs.mem_low;
      `CSSCR_OFS_IDENTITY: next_s.rd_data = CHIP_ID; // RULE_14
      default: next_s.rd_data = 8'h00;
    endcase
  end

  // Defaults load only under the power-on reset. RULE_18 RULE_15
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s.regs.freq_spread <= `CSSCR_RST_FREQ_SPREAD;
      s.regs.cpu_en      <= `CSSCR_RST_CPU_EN;
      s.regs.pci_en      <= `CSSCR_RST_PCI_EN;
      s.regs.misc        <= `CSSCR_RST_MISC;
      s.regs.mem_high    <= `CSSCR_RST_MEM_HIGH;
      s.regs.mem_low     <= `CSSCR_RST_MEM_LOW;
      s.rd_data          <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rd_data;
  assign regs_o    = s.regs;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  a_identity_fixed: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) rd_idx_i == `CSSCR_OFS_IDENTITY |=>
    rd_data_o == CHIP_ID) else $error("Identity byte read wrong."); // RULE_14
  a_strap_bit_ro: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) wr_en_i |=> $stable(s.regs.cpu_en[7]) &&
    $stable(s.regs.misc[6])) else $error("Strap bit written."); // RULE_12
  a_strap_readback: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i) rd_idx_i == `CSSCR_OFS_CPU_EN |=>
    rd_data_o[7] == $past(straps_i[2])) else $error("Strap readback."); // RULE_12

endmodule : csscr_reg_bank
`default_nettype wire

// *** csscr_host_model.sv ***
// Serial bus host model that drives the clock pin and pulls the data wire.
`timescale 1ns/1ps
`default_nettype none

module csscr_host_model (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // The bus idles high from time zero, as the slave expects after reset.
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // Each phase is 8 clocks, twice the slave's minimum, to leave margin.
  task automatic ph;
    repeat (8) @(negedge ref_clk_i);
  endtask : ph

  // Start: data falls while the clock is high.
  task automatic start;
    sda_low_o = 1'b1;
    ph();
    scl_o = 1'b0;
    ph();
  endtask : start

  // Stop: data rises while the clock is high.
  task automatic stop;
    sda_low_o = 1'b1;
    ph();
    scl_o = 1'b1;
    ph();
    sda_low_o = 1'b0;
    ph();
  endtask : stop

  // One bit; data moves a clock after the fall so it never looks like a stop.
  task automatic bt(input logic b, output logic r);
    sda_low_o = !b;
    ph();
    scl_o = 1'b1;
    ph();
    r = sda_i;
    scl_o = 1'b0;
    @(negedge ref_clk_i);
  endtask : bt

  // A byte goes MSB first, then the ack bit; a one releases the wire.
  task automatic xb(input logic [7:0] tx, input logic ak,
                    output logic [7:0] rx, output logic ar);
    for (int i = 7; i >= 0; i--) bt(tx[i], rx[i]);
    bt(ak, ar);
  endtask : xb
endmodule : csscr_host_model

`default_nettype wire

// *** test_clock_synth_serial_control_regs.sv ***
// Self-checking bench for the serial-programmed clock control bank.
`timescale 1ns/1ps
`default_nettype none

module test_clock_synth_serial_control_regs;
  localparam logic [7:0] ID = 8'h3c;  // Arbitrary value.
  logic                      ref_clk_i = 1'b0;
  logic                      reset_n_i = 1'b0;
  logic [3:0]                straps    = 4'h3;
  logic                      scl;
  logic                      sda_low;
  logic                      sda_oe;
  logic                      sda_out;
  logic                      strap_valid;
  csscr_pkg::csscr_ctrl_type ctrl;
  int                        miscompares = 0;
  int                        samples_checked = 0;
  // The data wire has a pull-up; any party may pull it low, and the slave
  // shows its open-drain data value while its enable is high.
  wire logic                 sda = !(sda_low | (sda_oe & !sda_out));

  always #10 ref_clk_i = ~ref_clk_i;

  csscr_top #(.CHIP_ID(ID)) dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe), .freq_strap_i(straps),
    .strap_valid_o(strap_valid), .ctrl_o(ctrl));

  csscr_host_model host (
    .ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic chk(input string n, input logic [39:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // Two ignored bytes precede the data, which lands from byte 0 on.
  task automatic wr(input logic [7:0] a, input logic [7:0] d [7]);
    logic [7:0] r;
    logic       k;
    host.start();
    host.xb(a, 1'b1, r, k);
    chk("wr ack", k, a != 8'hd2);
    host.xb(8'h00, 1'b1, r, k);
    host.xb(8'h07, 1'b1, r, k);
    for (int i = 0; i < 7; i++) host.xb(d[i], 1'b1, r, k);
    host.stop();
  endtask : wr

  // Reads start at byte 0; the last byte is refused before the stop.
  task automatic rd(input logic [7:0] e [7]);
    logic [7:0] r;
    logic       a;
    host.start();
    host.xb(8'hd3, 1'b1, r, a);
    chk("rd ack", a, 1'b0);
    for (int i = 0; i < 7; i++) begin
      host.xb(8'hff, i == 6, r, a);
      chk("rd byte", r, e[i]);
    end
    host.stop();
  endtask : rd

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_power;
    for (int i = 0; i < 60 && strap_valid !== 1'b1; i++)
      @(negedge ref_clk_i);
    chk("strap_valid", strap_valid, 1'b1);
    // The index output follows the latched straps one clock later.
    @(negedge ref_clk_i);
    chk("ctrl", ctrl, {4'h3, 4'h0, 1'b0, 3'h7, 7'h7f, 14'h3fff,
        3'h7, 2'h3});
    rd('{8'h00, 8'h7f, 8'hff, 8'hff, 8'hfd, 8'hff, ID});
    $display("power-up test done");
  endtask : t_power

  // Read-only bits and the identity byte must survive the write.
  task automatic t_write;
    wr(8'hd2, '{8'hef, 8'h80, 8'h2a, 8'h4d, 8'h50, 8'hc3, 8'h00});
    chk("ctrl", ctrl, {4'he, 2'h3, 2'h2, 1'b1, 3'h0, 7'h2a, 14'h14c3,
        3'h0, 2'h1});
    rd('{8'hef, 8'h00, 8'h2a, 8'h4d, 8'h58, 8'hc3, ID});
    $display("write test done");
  endtask : t_write

  // Every spread mode, then a wrong address that must change nothing.
  task automatic t_modes;
    logic [7:0] m0 [3] = '{8'h82, 8'h02, 8'h82};
    logic [7:0] m1 [3] = '{8'h20, 8'h20, 8'h00};
    logic [1:0] em [3] = '{2'h1, 2'h0, 2'h2};
    for (int i = 0; i < 3; i++) begin
      wr(8'hd2, '{m0[i], m1[i], 8'hff, 8'hff, 8'hff, 8'hff, 8'h00});
      chk("mode", ctrl.spread_mode, em[i]);
      chk("index", ctrl.freq_index, 4'h3);
      chk("spread", ctrl.spread_en, 1'b1);
    end
    wr(8'hd4, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("mode", ctrl.spread_mode, 2'h2);
    chk("pci", ctrl.pci_en, 7'h7f);
    $display("mode test done");
  endtask : t_modes

  // The whole run needs about 10400 clocks.
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (16) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    t_power();
    t_write();
    t_modes();
    stop_test();
  end
endmodule : test_clock_synth_serial_control_regs

`default_nettype wire
